// ===== frp_pkg.sv
// shared constants and types for the flash row program call sequencer
package frp_pkg;

    // register bus byte offsets
    localparam logic [7:0]  OFF_DATA_WORD   = 8'h00;  // ipc_call_data_word
    localparam logic [7:0]  OFF_CALL_STATE  = 8'h04;  // sequencer state, read only

    // parameter block word offsets from the parameter_block_pointer
    localparam logic [31:0] PB_OFF_WORD0    = 32'h0;
    localparam logic [31:0] PB_OFF_WORD1    = 32'h4;
    localparam logic [31:0] PB_OFF_TARGET   = 32'h8;
    localparam logic [31:0] PB_OFF_DATA0    = 32'hC;
    localparam logic [31:0] PB_WORD_STRIDE  = 32'h4;

    // field positions in the first parameter word
    localparam int          W0_OPCODE_LSB   = 24;
    localparam int          W0_BLANK_LSB    = 16;
    localparam int          W0_BLOCK_LSB    = 8;
    localparam int          W0_STALL_BIT    = 2;
    localparam int          W0_HV_BIT       = 1;
    // field positions in the second parameter word
    localparam int          W1_VERIFY_LSB   = 16;
    localparam int          W1_SOURCE_LSB   = 8;

    // field values
    localparam logic [7:0]  OPCODE_ROW_PROGRAM = 8'h06;
    localparam logic [7:0]  BLANK_SKIP         = 8'h01;
    localparam logic [7:0]  BLOCKING_ON        = 8'h01;
    localparam logic [7:0]  VERIFY_ON          = 8'h01;
    localparam logic [7:0]  SOURCE_SRAM        = 8'h01;

    // returned status word
    localparam logic [3:0]  STATUS_SUCCESS  = 4'hA;
    localparam logic [3:0]  STATUS_ERROR    = 4'hF;
    localparam logic [27:0] ERR_NONE        = 28'h0;
    localparam logic [27:0] ERR_BAD_OPCODE  = 28'h1;
    localparam logic [27:0] ERR_NOT_BLANK   = 28'h2;
    localparam logic [27:0] ERR_ROW_COMPARE = 28'h3;  // row_compare_fail_status

    // reset values
    localparam logic [31:0] DATA_WORD_RESET = 32'h0;

    // call sequencer states
    typedef enum logic [2:0] {
        FRP_IDLE,
        FRP_FETCH_HDR,
        FRP_BLANK,
        FRP_LOAD,
        FRP_PROG,
        FRP_WAIT,
        FRP_VERIFY,
        FRP_REPORT
    } frp_state_t;

endpackage

// ===== frp_param_fetch.sv
// single word wishbone read master that fetches parameter block words
`timescale 1ns/1ps
module frp_param_fetch
    import frp_pkg::*;
(
    input  wire logic        core_clk_in, // system clock
    input  wire logic        reset_n_in, // sync reset, active low
    input  wire logic        go_in, // pulse: start one read
    input  wire logic [31:0] addr_in, // byte address of the word
    output logic             done_out, // pulse: word arrived
    output logic [31:0]      data_out, // fetched word
    output logic             m_cyc_out, // master cycle
    output logic             m_stb_out, // master strobe
    output logic             m_we_out, // always read
    output logic [3:0]       m_sel_out, // all lanes
    output logic [31:0]      m_adr_out, // word address
    input  wire logic        m_ack_in, // ack
    input  wire logic [31:0] m_dat_in // read data
);

    logic        busy_q, busy_d; // request in flight
    logic [31:0] adr_q, adr_d; // held address
    logic        done_q, done_d; // registered completion
    logic [31:0] data_q, data_d; // registered read data

    // hold the request until ack, then drop it
    always_comb begin
        busy_d = busy_q;
        adr_d  = adr_q;
        done_d = 1'b0;
        data_d = data_q;
        if (busy_q) begin
            if (m_ack_in) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                data_d = m_dat_in;
            end
        end else if (go_in && !done_q) begin
            // word aligned by construction
            busy_d = 1'b1;
            adr_d  = {addr_in[31:2], 2'b00};
        end
    end

    // registers
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            busy_q <= 1'b0;
            adr_q  <= 32'h0;
            done_q <= 1'b0;
            data_q <= 32'h0;
        end else begin
            busy_q <= busy_d;
            adr_q  <= adr_d;
            done_q <= done_d;
            data_q <= data_d;
        end
    end

    assign m_cyc_out = busy_q;
    assign m_stb_out = busy_q;
    assign m_we_out  = 1'b0;
    assign m_sel_out = 4'hF;
    assign m_adr_out = adr_q;
    assign done_out  = done_q;
    assign data_out  = data_q;

endmodule

// ===== frp_row_program.sv
// flash row program call sequencer with wishbone register slave
// What this block does
// R1 - caller erases target row first
// R2 - phase one arms, call stays owned
// R3 - owned call refuses further calls
// R4 - done event runs phase two, release
// R5 - verify mismatch gives row compare fail
// R6 - parameters in, status out, one word
// R7 - data word holds aligned block pointer
// R8 - word zero top byte is opcode
// R9 - blank check skipped only for one
// R10 - blocking one holds the boot core
// R11 - bit two stalls all reads
// R12 - bit one selects hardware voltage pulses
// R13 - word one field one enables verify
// R14 - source: zero latch, one block
// R15 - word two holds target byte address
// R16 - data words from offset twelve
// R17 - software manages core supply
// R18 - no reset or sleep mid program
// R19 - status nibble A pass, F error
// R20 - ascending fetch, low byte ignored
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module frp_row_program
    import frp_pkg::*;
#(
    parameter int              ROW_WORDS   = 16, // words per flash row
    parameter int              DATA_W      = 32, // data bits per word
    parameter logic [31:0]     ERASED_WORD = 32'h0 // erased flash content
)(
    input  wire logic              core_clk_in, // system clock
    input  wire logic              reset_n_in, // sync reset, active low
    // register slave
    input  wire logic              wb_cyc_in, // bus cycle
    input  wire logic              wb_stb_in, // bus strobe
    input  wire logic              wb_we_in, // write enable
    input  wire logic [7:0]        wb_adr_in, // byte address
    input  wire logic [3:0]        wb_sel_in, // byte lanes
    input  wire logic [31:0]       wb_dat_in, // write data
    output logic [31:0]            wb_dat_out, // read data
    output logic                   wb_ack_out, // acknowledge
    // parameter block master
    output logic                   m_cyc_out, // cycle
    output logic                   m_stb_out, // strobe
    output logic                   m_we_out, // always low
    output logic [3:0]             m_sel_out, // byte lanes
    output logic [31:0]            m_adr_out, // address
    input  wire logic              m_ack_in, // acknowledge
    input  wire logic [31:0]       m_dat_in, // read data
    // flash macro
    output logic [31:0]            flash_target_out, // target byte address
    output logic [$clog2(ROW_WORDS)-1:0] row_word_idx_out, // word index for reads
    output logic                   flash_rd_req_out, // row word read request
    input  wire logic              flash_rd_ack_in, // read data valid
    input  wire logic [31:0]       flash_rd_data_in, // flash row word
    input  wire logic [DATA_W-1:0] latch_rd_data_in, // row latch word at index
    output logic                   latch_we_out, // row latch write pulse
    output logic [$clog2(ROW_WORDS)-1:0] latch_idx_out, // row latch write index
    output logic [DATA_W-1:0]      latch_data_out, // row latch write data
    output logic                   prog_start_out, // pulse: start programming
    input  wire logic              flash_done_in, // programming done event
    output logic                   hw_hv_ctrl_out, // hardware voltage pulses
    output logic                   read_stall_all_out, // stall every flash read
    output logic                   boot_core_hold_out, // hold the boot core
    output logic                   call_owned_out // ipc structure held
);

    localparam int IDX_W = $clog2(ROW_WORDS);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ROW_WORDS - 1);

    // refuse shapes the logic cannot serve
    if (ROW_WORDS < 2 || DATA_W < 1 || DATA_W > 32) begin : g_bad_params
        $error("unsupported ROW_WORDS or DATA_W");
    end

    // sequencer state
    frp_state_t        state_q, state_d;
    logic [31:0]       data_word_q, data_word_d; // ipc_call_data_word
    logic              owned_q, owned_d; // ipc structure held
    logic [1:0]        hdr_idx_q, hdr_idx_d; // header word being fetched
    logic [31:0]       w0_q, w0_d; // first parameter word
    logic [31:0]       w1_q, w1_d; // second parameter word
    logic [31:0]       target_q, target_d; // flash target address
    logic [IDX_W-1:0]  idx_q, idx_d; // row word index
    logic              fail_q, fail_d; // call failed
    logic [27:0]       err_q, err_d; // error code
    logic              fwait_q, fwait_d; // fetch in flight
    logic              lwe_q, lwe_d; // latch write pulse
    logic [IDX_W-1:0]  lidx_q, lidx_d; // latch write index
    logic [DATA_W-1:0] ldat_q, ldat_d; // latch write data
    logic              prog_q, prog_d; // program start pulse

    // bus state
    logic              ack_q, ack_d; // registered ack
    logic [31:0]       rdat_q, rdat_d; // registered read data

    // fetcher handshake
    logic              fetch_go; // start a word read
    logic [31:0]       fetch_addr; // byte address of the word
    logic              fetch_done; // word arrived
    logic [31:0]       fetch_data; // fetched word

    // bus decode results
    logic              bus_accept; // request taken this cycle
    logic              bus_wr_word; // write to the data word
    logic [31:0]       bus_merged; // data word after byte lanes
    logic [31:0]       call_state; // read view of the sequencer

    // decoded parameter fields
    logic              blank_skip;
    logic              src_sram;
    logic              verify_on;
    logic              blocking;
    logic [7:0]        opcode_new;

    assign blank_skip = (w0_q[W0_BLANK_LSB +: 8] == BLANK_SKIP);  // R9
    assign blocking   = (w0_q[W0_BLOCK_LSB +: 8] == BLOCKING_ON);  // R10
    assign verify_on  = (w1_q[W1_VERIFY_LSB +: 8] == VERIFY_ON);   // R13
    assign src_sram   = (w1_q[W1_SOURCE_LSB +: 8] == SOURCE_SRAM); // R14
    assign opcode_new = fetch_data[W0_OPCODE_LSB +: 8];

    // bus slave: decode, byte lanes and read mux
    always_comb begin
        bus_accept  = wb_cyc_in && wb_stb_in && !ack_q;
        bus_wr_word = bus_accept && wb_we_in && (wb_adr_in == OFF_DATA_WORD);
        bus_merged  = data_word_q;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_in[b]) begin
                bus_merged[8*b +: 8] = wb_dat_in[8*b +: 8];
            end
        end
        call_state = {26'h0, state_q, blocking && owned_q, fail_q, owned_q};
        ack_d  = bus_accept;
        rdat_d = rdat_q;
        if (bus_accept && !wb_we_in) begin
            if (wb_adr_in == OFF_DATA_WORD) begin
                rdat_d = data_word_q;
            end else if (wb_adr_in == OFF_CALL_STATE) begin
                rdat_d = call_state;
            end else begin
                // unmapped: acked, reads zero
                rdat_d = 32'h0;
            end
        end
    end

    // bus registers
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // sequencer next values
    always_comb begin
        state_d     = state_q;
        data_word_d = data_word_q;
        owned_d     = owned_q;
        hdr_idx_d   = hdr_idx_q;
        w0_d        = w0_q;
        w1_d        = w1_q;
        target_d    = target_q;
        idx_d       = idx_q;
        fail_d      = fail_q;
        err_d       = err_q;
        lwe_d       = 1'b0;
        lidx_d      = lidx_q;
        ldat_d      = ldat_q;
        prog_d      = 1'b0;
        fetch_go    = 1'b0;
        fetch_addr  = 32'h0;
        case (state_q)
            FRP_IDLE: begin
                // only idle takes a call; owned writes are ignored
                if (bus_wr_word && !owned_q) begin  // R3
                    data_word_d = bus_merged;  // R6 R7
                    owned_d     = 1'b1;
                    hdr_idx_d   = 2'd0;
                    w0_d        = 32'h0;
                    w1_d        = 32'h0;
                    fail_d      = 1'b0;
                    err_d       = ERR_NONE;
                    state_d     = FRP_FETCH_HDR;
                end
            end
            FRP_FETCH_HDR: begin
                // header words at ascending offsets 0, 4, 8
                fetch_go   = !fwait_q;  // R20
                fetch_addr = data_word_q + PB_OFF_WORD0 + {28'h0, hdr_idx_q, 2'b00};
                if (fetch_done) begin
                    hdr_idx_d = hdr_idx_q + 2'd1;
                    if (hdr_idx_q == 2'd0) begin
                        w0_d = fetch_data;
                        if (opcode_new != OPCODE_ROW_PROGRAM) begin  // R8
                            fail_d  = 1'b1;
                            err_d   = ERR_BAD_OPCODE;
                            state_d = FRP_REPORT;
                        end
                    end else if (hdr_idx_q == 2'd1) begin
                        // low byte is unused and dropped
                        w1_d = {fetch_data[31:8], 8'h00};  // R20
                    end else begin
                        target_d = fetch_data;  // R15
                        idx_d    = '0;
                        if (!blank_skip) begin  // R9
                            state_d = FRP_BLANK;
                        end else if (src_sram) begin  // R14
                            state_d = FRP_LOAD;
                        end else begin
                            state_d = FRP_PROG;
                        end
                    end
                end
            end
            FRP_BLANK: begin
                // each row word must read erased
                if (flash_rd_ack_in) begin
                    if (flash_rd_data_in != ERASED_WORD) begin  // R9
                        fail_d  = 1'b1;
                        err_d   = ERR_NOT_BLANK;
                        state_d = FRP_REPORT;
                    end else if (idx_q == LAST_IDX) begin
                        idx_d   = '0;
                        state_d = src_sram ? FRP_LOAD : FRP_PROG;  // R14
                    end else begin
                        idx_d = idx_q + 1'b1;
                    end
                end
            end
            FRP_LOAD: begin
                // data word n sits at offset 12 + 4n
                fetch_go   = !fwait_q;  // R16 R20
                fetch_addr = data_word_q + PB_OFF_DATA0
                           + (32'(idx_q) * PB_WORD_STRIDE);
                if (fetch_done) begin
                    lwe_d  = 1'b1;
                    lidx_d = idx_q;
                    ldat_d = fetch_data[DATA_W-1:0];  // R16
                    if (idx_q == LAST_IDX) begin
                        idx_d   = '0;
                        state_d = FRP_PROG;
                    end else begin
                        idx_d = idx_q + 1'b1;
                    end
                end
            end
            FRP_PROG: begin
                // phase one: start, hand back unless blocking, stay owned
                prog_d  = 1'b1;  // R2
                state_d = FRP_WAIT;
                if (!blocking) begin
                    data_word_d = {STATUS_SUCCESS, ERR_NONE};  // R19 R10
                end
            end
            FRP_WAIT: begin
                // done event starts phase two
                if (flash_done_in) begin  // R4
                    idx_d   = '0;
                    state_d = verify_on ? FRP_VERIFY : FRP_REPORT;  // R13
                end
            end
            FRP_VERIFY: begin
                // row against latch, per word
                if (flash_rd_ack_in) begin
                    if (flash_rd_data_in[DATA_W-1:0] != latch_rd_data_in) begin  // R5
                        fail_d  = 1'b1;
                        err_d   = ERR_ROW_COMPARE;
                        state_d = FRP_REPORT;
                    end else if (idx_q == LAST_IDX) begin
                        state_d = FRP_REPORT;
                    end else begin
                        idx_d = idx_q + 1'b1;
                    end
                end
            end
            FRP_REPORT: begin
                // final status, then release
                data_word_d = fail_q ? {STATUS_ERROR, err_q}
                                     : {STATUS_SUCCESS, ERR_NONE};  // R19 R6
                owned_d     = 1'b0;  // R4
                state_d     = FRP_IDLE;
            end
            default: begin
                state_d = FRP_IDLE;
            end
        endcase
        // fetch in flight from go until done
        if (fetch_go) begin
            fwait_d = 1'b1;
        end else if (fetch_done) begin
            fwait_d = 1'b0;
        end else begin
            fwait_d = fwait_q;
        end
    end

    // sequencer registers
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state_q     <= FRP_IDLE;
            data_word_q <= DATA_WORD_RESET;
            owned_q     <= 1'b0;
            hdr_idx_q   <= 2'd0;
            w0_q        <= 32'h0;
            w1_q        <= 32'h0;
            target_q    <= 32'h0;
            idx_q       <= '0;
            fail_q      <= 1'b0;
            err_q       <= ERR_NONE;
            fwait_q     <= 1'b0;
            lwe_q       <= 1'b0;
            lidx_q      <= '0;
            ldat_q      <= '0;
            prog_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            data_word_q <= data_word_d;
            owned_q     <= owned_d;
            hdr_idx_q   <= hdr_idx_d;
            w0_q        <= w0_d;
            w1_q        <= w1_d;
            target_q    <= target_d;
            idx_q       <= idx_d;
            fail_q      <= fail_d;
            err_q       <= err_d;
            fwait_q     <= fwait_d;
            lwe_q       <= lwe_d;
            lidx_q      <= lidx_d;
            ldat_q      <= ldat_d;
            prog_q      <= prog_d;
        end
    end

    // parameter block reader
    frp_param_fetch u_fetch (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .go_in       (fetch_go),
        .addr_in     (fetch_addr),
        .done_out    (fetch_done),
        .data_out    (fetch_data),
        .m_cyc_out   (m_cyc_out),
        .m_stb_out   (m_stb_out),
        .m_we_out    (m_we_out),
        .m_sel_out   (m_sel_out),
        .m_adr_out   (m_adr_out),
        .m_ack_in    (m_ack_in),
        .m_dat_in    (m_dat_in)
    );

    // outputs
    assign wb_dat_out         = rdat_q;
    assign wb_ack_out         = ack_q;
    assign flash_target_out   = target_q;
    assign row_word_idx_out   = idx_q;
    assign flash_rd_req_out   = (state_q == FRP_BLANK) || (state_q == FRP_VERIFY);
    assign latch_we_out       = lwe_q;
    assign latch_idx_out      = lidx_q;
    assign latch_data_out     = ldat_q;
    assign prog_start_out     = prog_q;
    assign hw_hv_ctrl_out     = owned_q && w0_q[W0_HV_BIT];  // R12
    assign read_stall_all_out = owned_q && w0_q[W0_STALL_BIT]
                              && (state_q == FRP_WAIT);  // R11
    assign boot_core_hold_out = owned_q && blocking;  // R10
    assign call_owned_out     = owned_q;

endmodule

// ===== frp_row_program_monitor.sv
// port checker for the row program call sequencer
`timescale 1ns/1ps
module frp_row_program_monitor (
    input wire logic        core_clk_in,
    input wire logic        reset_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_ack_out,
    input wire logic        m_stb_out,
    input wire logic        m_cyc_out,
    input wire logic        m_we_out,
    input wire logic [31:0] m_adr_out,
    input wire logic        m_ack_in,
    input wire logic        prog_start_out,
    input wire logic        flash_done_in,
    input wire logic        read_stall_all_out,
    input wire logic        hw_hv_ctrl_out,
    input wire logic        boot_core_hold_out,
    input wire logic        call_owned_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    bus_ack_a:
        assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("register ack timing");
    call_take_a:
        assert property ($rose(call_owned_out) |-> wb_ack_out) else $error("call owned no ack");
    start_pulse_a:
        assert property (prog_start_out |-> call_owned_out ##1 !prog_start_out)
        else $error("program start");
    stall_owned_a:
        assert property (read_stall_all_out |-> call_owned_out && !m_cyc_out)
        else $error("stall outside call");
    mode_owned_a:
        assert property (boot_core_hold_out || hw_hv_ctrl_out |-> call_owned_out)
        else $error("mode outside call");
    done_free_a:
        assert property (read_stall_all_out && flash_done_in |-> ##[1:60] !call_owned_out)
        else $error("call not released");
    fetch_read_a:
        assert property (m_cyc_out |-> !m_we_out && m_adr_out[1:0] == 2'h0) else $error("fetch");
    fetch_hold_a:
        assert property (m_stb_out && !m_ack_in |=> m_stb_out && $stable(m_adr_out))
        else $error("fetch dropped");
    cover property (prog_start_out);
    cover property (flash_done_in && call_owned_out);
    cover property (m_stb_out && !m_ack_in);
endmodule

// ===== frp_far_model.sv
// parameter block memory and flash row model on the far side
`timescale 1ns/1ps
module frp_far_model (
    input  wire logic        core_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        m_stb_in,
    input  wire logic [31:0] m_adr_in,
    output logic             m_ack_out,
    output logic [31:0]      m_dat_out,
    input  wire logic        rd_req_in,
    input  wire logic [1:0]  rd_idx_in,
    output logic             rd_ack_out,
    output logic [31:0]      rd_data_out,
    input  wire logic        lat_we_in,
    input  wire logic [1:0]  lat_idx_in,
    input  wire logic [31:0] lat_data_in,
    output logic [31:0]      lat_rd_out,
    input  wire logic        prog_in,
    output logic             done_out,
    input  wire logic [1:0]  fault_in
);
    logic [31:0] mem [8]; // parameter block, ascending words
    logic [31:0] lat [4]; // row latch
    logic        pgm;     // row holds the latch image
    logic [1:0]  n, wt;   // wait count, prompt or slow
    logic [4:0]  dly;     // cycles to completion event
    assign lat_rd_out = lat[rd_idx_in];
    // sram slave; an idle data bus flips to the inverse of its value every cycle
    always_ff @(posedge core_clk_in) begin
        m_ack_out <= 1'b0;
        m_dat_out <= ~m_dat_out;
        n <= n + 2'h1;
        if (!reset_n_in) begin
            {n, wt, m_dat_out} <= '0;
        end else if (!m_stb_in || m_ack_out) begin
            n <= '0;
        end else if (n == wt) begin
            m_ack_out <= 1'b1;
            m_dat_out <= mem[m_adr_in[4:2]];
            wt <= ~wt;
        end
    end
    // flash row reads, latch writes, program and completion event
    always_ff @(posedge core_clk_in) begin
        rd_ack_out <= rd_req_in && !rd_ack_out;
        rd_data_out <= ~rd_data_out;
        if (rd_req_in && !rd_ack_out) begin
            rd_data_out <= pgm ? lat[rd_idx_in] ^ {31'h0, fault_in[1]} : {32{fault_in[0]}};
        end
        if (lat_we_in) begin
            lat[lat_idx_in] <= lat_data_in;
        end
        dly <= prog_in ? 5'h14 : dly - {4'h0, dly != 5'h0};
        done_out <= dly == 5'h1;
        if (prog_in) begin
            pgm <= 1'b1;
        end else if (!reset_n_in || m_ack_out && m_adr_in[4:2] == 3'h0) begin
            pgm <= 1'b0;
        end
        if (!reset_n_in) begin
            {rd_ack_out, rd_data_out, dly, done_out} <= '0;
        end
    end
endmodule

// ===== frp_row_program_tb_top.sv
// self-checking bench for the row program call sequencer
`timescale 1ns/1ps
module frp_row_program_tb_top;
    import frp_pkg::*;
    logic        core_clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
    logic [7:0]  wb_adr_in;
    logic [3:0]  wb_sel_in, m_sel_out;
    logic [31:0] wb_dat_in, wb_dat_out, m_adr_out, m_dat_in, flash_target_out, rd;
    logic [31:0] flash_rd_data_in, latch_rd_data_in, latch_data_out;
    logic [1:0]  row_word_idx_out, latch_idx_out, fault;
    logic        m_cyc_out, m_stb_out, m_we_out, m_ack_in, flash_rd_req_out, flash_rd_ack_in;
    logic        latch_we_out, prog_start_out, flash_done_in, hw_hv_ctrl_out;
    logic        read_stall_all_out, boot_core_hold_out, call_owned_out;
    int          num_errors, samples_checked, ticks;
    frp_row_program #(.ROW_WORDS(4)) DUT (.*);
    frp_far_model u_far (.core_clk_in, .reset_n_in, .m_stb_in(m_stb_out), .m_adr_in(m_adr_out),
        .m_ack_out(m_ack_in), .m_dat_out(m_dat_in), .rd_req_in(flash_rd_req_out),
        .rd_idx_in(row_word_idx_out), .rd_ack_out(flash_rd_ack_in),
        .rd_data_out(flash_rd_data_in), .lat_we_in(latch_we_out), .lat_idx_in(latch_idx_out),
        .lat_data_in(latch_data_out), .lat_rd_out(latch_rd_data_in),
        .prog_in(prog_start_out), .done_out(flash_done_in), .fault_in(fault));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle, held until ack
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, wb_sel_in} <= {2'h3, w, a, d, 4'hF};
        do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'h0;
    endtask
    task automatic start(logic [31:0] w0, logic [31:0] w1);
        u_far.mem[0] = w0;
        u_far.mem[1] = w1;
        wb(1'b1, OFF_DATA_WORD, 32'h0000_0100);
    endtask
    task automatic done_chk(logic [31:0] exp);
        for (int i = 0; i < 300 && call_owned_out !== 1'b0; i++) @(posedge core_clk_in);
        wb(1'b0, OFF_DATA_WORD, '0);
        chk("status", rd, exp);
    endtask
    task automatic prog_wait;
        for (int i = 0; i < 300 && prog_start_out !== 1'b1; i++) @(posedge core_clk_in);
        @(posedge core_clk_in);
    endtask
    task automatic t_regs;
        wb(1'b0, OFF_DATA_WORD, '0);
        chk("reset word", rd, DATA_WORD_RESET);
        wb(1'b1, OFF_CALL_STATE, 32'hFFFF_FFFF);
        wb(1'b0, OFF_CALL_STATE, '0);
        chk("state", rd, 32'h0);
        wb(1'b0, 8'h20, '0);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic t_back; // non-blocking, sram data, verify passes
        start(32'h0601_0006, 32'h0001_01FF);
        prog_wait();
        chk("stall", read_stall_all_out, 1);
        chk("hv", hw_hv_ctrl_out, 1);
        chk("hold", boot_core_hold_out, 0);
        chk("target", flash_target_out, 32'h1000_0004);
        wb(1'b1, OFF_DATA_WORD, 32'h0000_0123);
        wb(1'b0, OFF_DATA_WORD, '0);
        chk("phase one", rd, 32'hA000_0000);
        done_chk(32'hA000_0000);
        for (int i = 0; i < 4; i++) chk("latch", u_far.lat[i], 32'hC0DE_0000 + i);
    endtask
    task automatic t_bad; // blocking call fails verify, then not blank, then bad opcode
        fault <= 2'h2;
        start(32'h0600_0100, 32'h0001_0000);
        prog_wait();
        chk("hold", boot_core_hold_out, 1);
        done_chk(32'hF000_0003);
        fault <= 2'h1;
        start(32'h0600_0000, 32'h0);
        done_chk(32'hF000_0002);
        fault <= 2'h0;
        start(32'h0501_0000, 32'h0);
        done_chk(32'hF000_0001);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #4 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        ticks++;
        if (ticks == 5000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        {core_clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, fault} = '0;
        {wb_adr_in, wb_dat_in, wb_sel_in} = '0;
        u_far.mem[2] = 32'h1000_0004;
        for (int i = 0; i < 4; i++) u_far.mem[3+i] = 32'hC0DE_0000 + i;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_back();
        t_bad();
        conclude();
    end
endmodule
bind frp_row_program frp_row_program_monitor u_mon (.*);
